// file: design/i2cr_slave.sv
`timescale 1ns/10ps
`include "i2cr_regs.svh"
module i2cr_slave #(
  parameter int STRAP_W = 3
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [STRAP_W-1:0] addr_strap_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [1:0] reg_port_o,
  output logic [11:2] reg_addr_o,
  output logic [3:0] reg_be_o,
  output logic [31:0] reg_wdata_o,
  input wire logic [31:0] reg_rdata_i
);

  if (STRAP_W < 1 || STRAP_W > 7) begin : g_check
    $error("STRAP_W must be 1 to 7");
  end

  function automatic logic [7:0] byte_of(input logic [31:0] word, input logic [1:0] idx);
    byte_of = word[31-8*idx -: 8];
  endfunction

  i2cr_pkg::i2cr_state_type state_reg;
  logic scl_q_reg, sda_q_reg;
  logic [STRAP_W-1:0] strap_reg;
  logic strap_done_reg;
  logic [7:0] shift_reg, tx_reg;
  logic [3:0] bit_cnt_reg, byte_cnt_reg;
  logic [1:0] rd_idx_reg;
  logic rw_reg, ack_reg, sda_oe_reg;
  logic [7:0] cmd0_reg, cmd1_reg, cmd2_reg, cmd3_reg;
  logic [31:0] wdata_reg, rd_buf_reg;
  logic wr_reg, rd_reg;

  wire start_det = scl_i & scl_q_reg & sda_q_reg & ~sda_i;
  wire stop_det = scl_i & scl_q_reg & ~sda_q_reg & sda_i;
  wire scl_rise = scl_i & ~scl_q_reg;
  wire scl_fall = ~scl_i & scl_q_reg;
  wire [6:0] my_addr = `I2CR_BASE_ADDR | 7'(strap_reg);
  wire addr_match = shift_reg[7:1] == my_addr;
  wire [2:0] opcode = cmd0_reg[`I2CR_OP_MSB:0];
  wire op_wr = opcode == `I2CR_OP_WR;
  wire op_rd = opcode == `I2CR_OP_RD;
  // acknowledge: address on match, command and four data bytes, else refuse
  wire ack_w = (byte_cnt_reg == `I2CR_CNT_ADDR) ? addr_match :
               (byte_cnt_reg < `I2CR_CNT_DATA_DONE);
  wire byte_done = (state_reg == i2cr_pkg::ST_RECV) && scl_fall && (bit_cnt_reg == 4'h8);
  wire ack_end = (state_reg == i2cr_pkg::ST_RACK) && scl_fall;
  wire to_send = ack_reg && rw_reg && (byte_cnt_reg == 4'h1);
  // register update only after the fourth data byte is acknowledged
  wire fire_wr = ack_end && ack_reg && !rw_reg && op_wr &&
                 (byte_cnt_reg == `I2CR_CNT_DATA_DONE);
  wire fire_rd = ack_end && ack_reg && !rw_reg && op_rd &&
                 (byte_cnt_reg == `I2CR_CNT_CMD_DONE);
  wire [7:0] first_tx = byte_of(rd_buf_reg, 2'h0);
  wire [7:0] next_tx = byte_of(rd_buf_reg, rd_idx_reg);

  assign sda_o = 1'b0;
  assign sda_oe_o = sda_oe_reg;
  assign reg_wr_o = wr_reg;
  assign reg_rd_o = rd_reg;
  assign reg_port_o = {cmd1_reg[`I2CR_PSEL_HI_BIT], cmd2_reg[`I2CR_PSEL_LO_BIT]};
  assign reg_addr_o = {cmd2_reg[`I2CR_AHI_MSB:0], cmd3_reg};
  assign reg_be_o = cmd2_reg[`I2CR_BE_MSB:`I2CR_BE_LSB];
  assign reg_wdata_o = wdata_reg;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_q_reg <= 1'b1;
      sda_q_reg <= 1'b1;
    end else begin
      scl_q_reg <= scl_i;
      sda_q_reg <= sda_i;
    end
  end

  // straps caught once after reset release
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      strap_reg <= '0;
      strap_done_reg <= 1'b0;
    end else if (!strap_done_reg) begin
      strap_reg <= addr_strap_i;
      strap_done_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_reg <= 1'b0;
      rd_reg <= 1'b0;
    end else begin
      wr_reg <= fire_wr;
      rd_reg <= fire_rd;
    end
  end

  // read data is taken during the fetch pulse
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_buf_reg <= `I2CR_RESET_WORD;
    end else if (rd_reg) begin
      rd_buf_reg <= reg_rdata_i;
    end
  end

  // received bytes sorted into address, command and data
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rw_reg <= 1'b0;
      cmd0_reg <= 8'h00;
      cmd1_reg <= 8'h00;
      cmd2_reg <= 8'h00;
      cmd3_reg <= 8'h00;
      wdata_reg <= `I2CR_RESET_WORD;
    end else if (byte_done) begin
      case (byte_cnt_reg)
        4'h0: rw_reg <= shift_reg[0];
        4'h1: cmd0_reg <= shift_reg;
        4'h2: cmd1_reg <= shift_reg;
        4'h3: cmd2_reg <= shift_reg;
        4'h4: cmd3_reg <= shift_reg;
        4'h5: wdata_reg[31:24] <= shift_reg;
        4'h6: wdata_reg[23:16] <= shift_reg;
        4'h7: wdata_reg[15:8] <= shift_reg;
        4'h8: wdata_reg[7:0] <= shift_reg;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= i2cr_pkg::ST_IDLE;
      shift_reg <= 8'h00;
      tx_reg <= 8'h00;
      bit_cnt_reg <= 4'h0;
      byte_cnt_reg <= 4'h0;
      rd_idx_reg <= 2'h0;
      ack_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
    end else if (start_det) begin
      // repeated start keeps the command bytes
      state_reg <= i2cr_pkg::ST_RECV;
      bit_cnt_reg <= 4'h0;
      byte_cnt_reg <= `I2CR_CNT_ADDR;
      sda_oe_reg <= 1'b0;
    end else if (stop_det) begin
      state_reg <= i2cr_pkg::ST_IDLE;
      sda_oe_reg <= 1'b0;
    end else begin
      case (state_reg)
        i2cr_pkg::ST_RECV: begin
          if (scl_rise) begin
            shift_reg <= {shift_reg[6:0], sda_i};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (byte_done) begin
            state_reg <= i2cr_pkg::ST_RACK;
            ack_reg <= ack_w;
            sda_oe_reg <= ack_w;
            if (byte_cnt_reg != `I2CR_CNT_DATA_DONE) begin
              byte_cnt_reg <= byte_cnt_reg + 4'h1;
            end
          end
        end
        i2cr_pkg::ST_RACK: begin
          if (scl_fall) begin
            bit_cnt_reg <= 4'h0;
            if (!ack_reg) begin
              state_reg <= i2cr_pkg::ST_WAIT;
              sda_oe_reg <= 1'b0;
            end else if (to_send) begin
              state_reg <= i2cr_pkg::ST_SEND;
              tx_reg <= first_tx;
              rd_idx_reg <= 2'h1;
              sda_oe_reg <= ~first_tx[7];
            end else begin
              state_reg <= i2cr_pkg::ST_RECV;
              sda_oe_reg <= 1'b0;
            end
          end
        end
        i2cr_pkg::ST_SEND: begin
          if (scl_fall) begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            if (bit_cnt_reg == 4'h7) begin
              state_reg <= i2cr_pkg::ST_MACK;
              sda_oe_reg <= 1'b0;
            end else begin
              tx_reg <= {tx_reg[6:0], 1'b0};
              sda_oe_reg <= ~tx_reg[6];
            end
          end
        end
        i2cr_pkg::ST_MACK: begin
          if (scl_rise) begin
            ack_reg <= ~sda_i;
          end else if (scl_fall) begin
            bit_cnt_reg <= 4'h0;
            if (ack_reg) begin
              state_reg <= i2cr_pkg::ST_SEND;
              tx_reg <= next_tx;
              rd_idx_reg <= rd_idx_reg + 2'h1;
              sda_oe_reg <= ~next_tx[7];
            end else begin
              state_reg <= i2cr_pkg::ST_WAIT;
            end
          end
        end
        i2cr_pkg::ST_IDLE, i2cr_pkg::ST_WAIT: begin
          sda_oe_reg <= 1'b0;
        end
        default: begin
          state_reg <= i2cr_pkg::ST_IDLE;
          sda_oe_reg <= 1'b0;
        end
      endcase
    end
  end

endmodule

// file: design/i2cr_regs.svh
`ifndef I2CR_REGS_SVH
`define I2CR_REGS_SVH

// bus address with all straps low
`define I2CR_BASE_ADDR 7'h38
// operation codes in command byte 0
`define I2CR_OP_WR 3'h3
`define I2CR_OP_RD 3'h4
// byte counter values: address, after last command, after last data
`define I2CR_CNT_ADDR 4'h0
`define I2CR_CNT_CMD_DONE 4'h5
`define I2CR_CNT_DATA_DONE 4'h9
// field positions in the command bytes
`define I2CR_OP_MSB 2
`define I2CR_PSEL_HI_BIT 0
`define I2CR_PSEL_LO_BIT 7
`define I2CR_BE_MSB 5
`define I2CR_BE_LSB 2
`define I2CR_AHI_MSB 1
`define I2CR_RESET_WORD 32'h0000_0000

`endif

// file: design/i2cr_pkg.sv
package i2cr_pkg;

  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_RECV = 6'b000010,
    ST_RACK = 6'b000100,
    ST_SEND = 6'b001000,
    ST_MACK = 6'b010000,
    ST_WAIT = 6'b100000
  } i2cr_state_type;

endpackage

// file: sim/i2cr_slave_chk.sv
`timescale 1ns/10ps
module i2cr_slave_chk #(
  parameter int STRAP_W = 3
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [STRAP_W-1:0] addr_strap_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic reg_wr_o,
  input wire logic reg_rd_o,
  input wire logic [1:0] reg_port_o,
  input wire logic [11:2] reg_addr_o,
  input wire logic [3:0] reg_be_o,
  input wire logic [31:0] reg_wdata_o,
  input wire logic [31:0] reg_rdata_i
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  chk_sda_open: assert property (sda_o == 1'b0)
    else $error("sda output not low");
  chk_oe_scl_high: assert property (scl_i && $past(scl_i) |-> $stable(sda_oe_o))
    else $error("sda drive changed while scl high");
  chk_oe_rise_low: assert property ($rose(sda_oe_o) |-> !scl_i && $past(scl_i, 2))
    else $error("sda drive not one clock after scl fall");
  chk_wr_gap: assert property (reg_wr_o |=> !reg_wr_o [*8])
    else $error("write pulses too close");
  chk_rd_gap: assert property (reg_rd_o |=> !reg_rd_o [*8])
    else $error("fetch pulses too close");
  chk_wr_scl_low: assert property (reg_wr_o |-> !scl_i)
    else $error("write not after ack clock fall");
  chk_rd_scl_low: assert property (reg_rd_o |-> !scl_i)
    else $error("fetch not after ack clock fall");
  chk_wr_rd_excl: assert property (!(reg_wr_o && reg_rd_o))
    else $error("write and fetch together");
  chk_wr_fields: assert property (reg_wr_o |->
    $stable(reg_port_o) && $stable(reg_addr_o) && $stable(reg_be_o))
    else $error("target fields moved at write");
endmodule
bind i2cr_slave i2cr_slave_chk #(.STRAP_W(STRAP_W)) u_i2cr_slave_chk (.*);

// file: sim/i2cr_mst.sv
`timescale 1ns/10ps
module i2cr_mst (
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic hp();
    repeat (4) @(negedge clk_i);
  endtask
  // also serves as repeated start
  task automatic start();
    sda_o = 1'b1;
    hp();
    scl_o = 1'b1;
    hp();
    sda_o = 1'b0;
    hp();
    scl_o = 1'b0;
  endtask
  task automatic stop();
    sda_o = 1'b0;
    hp();
    scl_o = 1'b1;
    hp();
    sda_o = 1'b1;
    hp();
  endtask
  // eight data bits then ack bit; a one releases the line
  task automatic xb(input logic [7:0] d, input logic ak_i, output logic [7:0] q,
    output logic ak);
    logic [8:0] s;
    logic [8:0] r;
    s = {d, ak_i};
    for (int i = 8; i >= 0; i--) begin
      sda_o = s[i];
      hp();
      scl_o = 1'b1;
      hp();
      r[i] = sda_i;
      scl_o = 1'b0;
    end
    q = r[8:1];
    ak = ~r[0];
  endtask
endmodule

// file: sim/i2c_slave_config_register_access_tb.sv
`timescale 1ns/10ps
module i2c_slave_config_register_access_tb;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [2:0] addr_strap_i = 3'h0;
  logic scl_i, sda_i, m_sda, sda_o, sda_oe_o, reg_wr_o, reg_rd_o, a;
  logic [1:0] reg_port_o;
  logic [11:2] reg_addr_o;
  logic [3:0] reg_be_o;
  logic [7:0] q;
  logic [31:0] reg_wdata_o, reg_rdata_i;
  logic [31:0] regv = 32'h0;
  int num_errors = 0, n_tests = 0, nwr = 0, nrd = 0, cyc = 0;
  // pull-up on the shared data line
  assign sda_i = m_sda & ~sda_oe_o;
  assign reg_rdata_i = regv ^ {22'h0, reg_addr_o};
  i2cr_slave u_i2cr_slave (.*);
  i2cr_mst u_i2cr_mst (.clk_i(clk_sys_i), .sda_i(sda_i), .scl_o(scl_i), .sda_o(m_sda));
  initial begin
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    nrd <= nrd + (reg_rd_o === 1'b1);
    if (reg_wr_o === 1'b1) begin
      nwr <= nwr + 1;
      for (int i = 0; i < 4; i++) if (reg_be_o[i]) regv[8*i+:8] <= reg_wdata_o[8*i+:8];
    end
    if (cyc == 20000) begin
      num_errors++;
      summarize();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wb(input logic [7:0] b, input logic ex);
    u_i2cr_mst.xb(b, 1'b1, q, a);
    chk("ack", a, ex);
  endtask
  task automatic bytes(input logic [31:0] d);
    for (int i = 3; i >= 0; i--) wb(d[8*i+:8], 1'b1);
  endtask
  task automatic cmd(input logic [7:0] ad, input logic [31:0] c);
    u_i2cr_mst.start();
    wb(ad, 1'b1);
    bytes(c);
  endtask
  task automatic rd(input logic [31:0] e, input int n);
    for (int i = 0; i < n; i++) begin
      u_i2cr_mst.xb(8'hff, i == n - 1, q, a);
      chk("rdata", q, e[8*(3-i%4)+:8]);
    end
    u_i2cr_mst.stop();
  endtask
  task automatic fld(input logic [31:0] p, ad, be, wd);
    chk("port", reg_port_o, p);
    chk("addr", reg_addr_o, ad);
    chk("be", reg_be_o, be);
    chk("wdata", reg_wdata_o, wd);
  endtask
  task summarize();
    $display("errors %0d tests %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (4) @(negedge clk_sys_i);
    rst_n_i = 1'b1;
    repeat (2) @(negedge clk_sys_i);
    cmd(8'h70, 32'h03003c2d);
    bytes(32'h12345678);
    wb(8'h99, 1'b0);
    u_i2cr_mst.stop();
    chk("nwr", nwr, 1);
    fld(32'h0, 32'h02d, 32'hf, 32'h12345678);
    cmd(8'h70, 32'hf30196a5);
    bytes(32'haabbccdd);
    u_i2cr_mst.stop();
    chk("nwr", nwr, 2);
    fld(32'h3, 32'h2a5, 32'h5, 32'haabbccdd);
    cmd(8'h70, 32'h05003c2d);
    bytes(32'h0);
    u_i2cr_mst.stop();
    chk("inv", nwr + nrd, 2);
    u_i2cr_mst.start();
    wb(8'h72, 1'b0);
    u_i2cr_mst.stop();
    cmd(8'h70, 32'h040196a5);
    u_i2cr_mst.stop();
    chk("nrd", nrd, 1);
    u_i2cr_mst.start();
    wb(8'h71, 1'b1);
    rd(32'h12bb5478, 8);
    cmd(8'h70, 32'h04003c2d);
    u_i2cr_mst.start();
    wb(8'h71, 1'b1);
    rd(32'h12bb56f0, 4);
    // straps are taken again after a mid-run reset
    addr_strap_i = 3'h5;
    rst_n_i = 1'b0;
    repeat (2) @(negedge clk_sys_i);
    rst_n_i = 1'b1;
    repeat (2) @(negedge clk_sys_i);
    u_i2cr_mst.start();
    wb(8'h70, 1'b0);
    u_i2cr_mst.start();
    wb(8'h7a, 1'b1);
    u_i2cr_mst.stop();
    summarize();
  end
endmodule
